/* hdl/filter_rate_config.sv */
// Function
// - Halving bit divides master clock by two
// - Single-cycle bit gives settled result per period
// - Ignore single-cycle with multichannel or one-shot
// - Averaging needs chopping for single-cycle effect
// - Dual notch bit adds 60 Hz notch
// - Rate is clock over 1024 over code
// - No chop: first notch equals data rate
// - Chop: divide also by sinc order
// - Chop: first notch is order times rate
// - Chop notches at odd multiples half rate
// - Order four by default, three when selected
//
// Holds the mode and control registers of the decimation filter and times
// each result from the master clock; assumes an AXI4-Lite master on clk_sys.
module filter_rate_config
  import filter_rate_pkg::*;
#(
  parameter int CountWidth = 24
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic convTick,
  output logic settledResult,
  output logic singleCycleActive,
  output logic dualNotchActive,
  output logic [2:0] sincOrder
);

  //////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [31:0] modeReg_q;
  logic [31:0] ctrlReg_q;
  logic [7:0] awaddr_q;
  logic awHave_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wHave_q;
  wr_state_t wrState_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Write channel handshake
  wire logic awTake = awvalid && !awHave_q && wrState_q == WrIdle;
  wire logic wTake = wvalid && !wHave_q && wrState_q == WrIdle;
  wire logic wrFire = awHave_q && wHave_q;
  wire logic wrMode = awaddr_q == ModeRegOffset;
  wire logic wrCtrl = awaddr_q == CtrlRegOffset;
  wire logic wrMapped = wrMode || wrCtrl ||
    awaddr_q == StatRegOffset ||
    awaddr_q == CountRegOffset;
  // A write to mode or control restarts timing and settling
  wire logic cfgWrite = wrFire && (wrMode || wrCtrl);
  logic [31:0] byteMask;

  // Byte lane masks
  for (genvar i = 0; i < 4; i++) begin : g_byteMask
    assign byteMask[i*8 +: 8] = {8{wstrb_q[i]}};
  end

  // Merged write words
  wire logic [31:0] modeMerged = (modeReg_q & ~byteMask) | (wdata_q & byteMask);
  wire logic [31:0] ctrlMerged = (ctrlReg_q & ~byteMask) | (wdata_q & byteMask);

  assign awready = !awHave_q && wrState_q == WrIdle;
  assign wready = !wHave_q && wrState_q == WrIdle;
  assign bvalid = wrState_q == WrResp;
  assign bresp = bresp_q;

  // Address channel capture
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      awHave_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (awTake) begin
      awHave_q <= 1'b1;
      awaddr_q <= {awaddr[7:2], 2'b00};
    end else if (wrFire) begin
      awHave_q <= 1'b0;
    end
  end

  // Data channel capture
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wHave_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (wTake) begin
      wHave_q <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (wrFire) begin
      wHave_q <= 1'b0;
    end
  end

  // Write response sequencing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrState_q <= WrIdle;
      bresp_q <= RespOkay;
    end else begin
      case (wrState_q)
        WrIdle: begin
          if (wrFire) begin
            wrState_q <= WrResp;
            bresp_q <= wrMapped ? RespOkay : RespSlvErr;
          end
        end
        WrResp: begin
          if (bready) begin
            wrState_q <= WrIdle;
          end
        end
        default: begin
          wrState_q <= WrIdle;
        end
      endcase
    end
  end

  // Mode register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      modeReg_q <= ModeRegReset;
    end else if (wrFire && wrMode) begin
      modeReg_q <= modeMerged;
    end
  end

  // Control register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrlReg_q <= CtrlRegReset;
    end else if (wrFire && wrCtrl) begin
      ctrlReg_q <= ctrlMerged;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channel

  logic [CountWidth-1:0] periodCnt_q;
  logic [31:0] statusWord;
  logic [31:0] countWord;
  // Address decode
  wire logic [7:0] arAligned = {araddr[7:2], 2'b00};
  wire logic rdMode = arAligned == ModeRegOffset;
  wire logic rdCtrl = arAligned == CtrlRegOffset;
  wire logic rdStat = arAligned == StatRegOffset;
  wire logic rdCount = arAligned == CountRegOffset;
  wire logic rdMapped = rdMode || rdCtrl || rdStat || rdCount;
  wire logic [31:0] rdMux = rdMode ? modeReg_q :
    rdCtrl ? ctrlReg_q :
    rdStat ? statusWord :
    rdCount ? countWord : 32'h0000_0000;

  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // Read answer, held until taken
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RespOkay;
    end else if (arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdMux;
      rresp_q <= rdMapped ? RespOkay : RespSlvErr;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Filter configuration

  filter_cfg_t cfg;
  assign cfg.clkHalve = modeReg_q[ClkHalvePos];
  assign cfg.singleCycle = modeReg_q[SingleCyclePos];
  assign cfg.dualMainsNotch = modeReg_q[DualNotchPos];
  assign cfg.orderSelect = modeReg_q[OrderSelPos];
  assign cfg.rateCode = modeReg_q[RatePos +: RateWidth];
  assign cfg.chop = ctrlReg_q[ChopPos];
  assign cfg.fastSettle = ctrlReg_q[FastSettlePos];
  assign cfg.oneShot = ctrlReg_q[OneShotPos];
  assign cfg.avgDecimate = ctrlReg_q[AvgDecPos];
  assign cfg.multiChan = ctrlReg_q[MultiChanPos];

  // Order four unless the order select bit is set
  assign sincOrder = cfg.orderSelect ? OrderThree : OrderFour;

  // Single-cycle settling only counts when no exception applies
  assign singleCycleActive = cfg.singleCycle && !cfg.multiChan && !cfg.oneShot &&
    (!cfg.avgDecimate || cfg.chop);

  // 60 Hz notch added; notch position itself is the analog filter's concern
  assign dualNotchActive = cfg.dualMainsNotch;

  //////////////////////////////////////////////////////////////////////////////
  // Conversion timing

  logic halfPhase_q;
  logic convTick_q;
  logic settled_q;
  logic [2:0] fillCnt_q;
  wire logic [CountWidth-1:0] rateExt = CountWidth'(cfg.rateCode);
  wire logic [CountWidth-1:0] frameBase = CountWidth'(rateExt * CountWidth'(FrameDivide));
  // With chopping the period grows by the sinc order, so notch is order x rate
  wire logic [CountWidth-1:0] framePeriod = cfg.chop ?
    CountWidth'(frameBase * CountWidth'(sincOrder)) : frameBase;
  // Halved master clock advances the count every other cycle
  wire logic mclkEn = cfg.clkHalve ? halfPhase_q : 1'b1;
  wire logic frameEnd = mclkEn && periodCnt_q + 1'b1 >= framePeriod;
  // Pipeline fill equals the order unless single-cycle settling is active
  wire logic [2:0] fillNeed = singleCycleActive ? 3'h1 : sincOrder;
  wire logic [2:0] fillNext = fillCnt_q + 3'h1;
  wire logic fillFull = fillNext >= fillNeed;

  // Halving phase
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      halfPhase_q <= 1'b0;
    end else begin
      halfPhase_q <= cfg.clkHalve ? !halfPhase_q : 1'b0;
    end
  end

  // Result tick, dropped when a reconfiguration restarts the count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      convTick_q <= 1'b0;
    end else begin
      convTick_q <= frameEnd && !cfgWrite;
    end
  end

  // Period counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      periodCnt_q <= '0;
    end else if (cfgWrite || frameEnd) begin
      periodCnt_q <= '0;
    end else if (mclkEn) begin
      periodCnt_q <= periodCnt_q + 1'b1;
    end
  end

  // Settling tracker
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fillCnt_q <= 3'h0;
      settled_q <= 1'b0;
    end else if (cfgWrite) begin
      fillCnt_q <= 3'h0;
      settled_q <= 1'b0;
    end else if (frameEnd) begin
      fillCnt_q <= fillFull ? fillNeed : fillNext;
      settled_q <= fillFull;
    end
  end

  assign convTick = convTick_q;
  assign settledResult = convTick_q && settled_q;
  assign statusWord = {
    24'h000000,
    1'b0,
    sincOrder,
    1'b0,
    dualNotchActive,
    singleCycleActive,
    settled_q
  };
  assign countWord = 32'(periodCnt_q);

endmodule

/* hdl/filter_rate_pkg.sv */
// Package for the decimation filter rate configuration block.
// Assumes a 100 MHz system clock and an AXI4-Lite master with 32-bit data.
package filter_rate_pkg;

  // Register byte offsets
  localparam logic [7:0] ModeRegOffset = 8'h00;
  localparam logic [7:0] CtrlRegOffset = 8'h04;
  localparam logic [7:0] StatRegOffset = 8'h08;
  localparam logic [7:0] CountRegOffset = 8'h0c;

  // Mode register fields
  localparam int RatePos = 0;
  localparam int RateWidth = 10;
  localparam int DualNotchPos = 10;
  localparam int SingleCyclePos = 11;
  localparam int ClkHalvePos = 12;
  localparam int OrderSelPos = 15;

  // Control register fields
  localparam int ChopPos = 0;
  localparam int FastSettlePos = 1;
  localparam int OneShotPos = 2;
  localparam int AvgDecPos = 3;
  localparam int MultiChanPos = 4;

  localparam logic [31:0] ModeRegReset = 32'h0000_0060;
  localparam logic [31:0] CtrlRegReset = 32'h0000_0000;

  localparam int FrameDivide = 1024;
  localparam logic [2:0] OrderFour = 3'h4;
  localparam logic [2:0] OrderThree = 3'h3;

  localparam logic [1:0] RespOkay = 2'h0;
  localparam logic [1:0] RespSlvErr = 2'h2;

  typedef struct packed {
    logic clkHalve;
    logic singleCycle;
    logic dualMainsNotch;
    logic orderSelect;
    logic chop;
    logic fastSettle;
    logic oneShot;
    logic avgDecimate;
    logic multiChan;
    logic [RateWidth-1:0] rateCode;
  } filter_cfg_t;

  typedef enum logic [1:0] {
    WrIdle,
    WrResp
  } wr_state_t;

endpackage

/* tb/filter_rate_config_test.sv */
// Self-checking bench for the filter rate block.
// Assumes the block alone, driven over AXI4-Lite.
module filter_rate_config_test
  import filter_rate_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid, convTick, settledResult;
  logic singleCycleActive, dualNotchActive;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] sincOrder;
  int bad_count = 0, tests_run = 0;
  integer seed = 32'h8756;
  logic [31:0] tm [5] = '{32'h1, 32'h802, 32'h8001, 32'h1801, 32'h803};
  logic [31:0] tc [5] = '{32'h0, 32'h0, 32'h1, 32'h9, 32'h4};
  filter_rate_config filter_rate_config_inst (.clk_sys, .rst_n, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .convTick, .settledResult,
    .singleCycleActive, .dualNotchActive, .sincOrder);
  initial forever #5 clk_sys = ~clk_sys;
  ////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 99) begin
      bad_count++;
      finish_test;
    end else begin
      r = bresp;
      bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 99) begin
      bad_count++;
      finish_test;
    end else begin
      d = rdata;
      r = rresp;
      rready <= 1'b0;
    end
  endtask
  task automatic waitTick(output int c);
    for (c = 1; c < 20000; c++) begin
      @(posedge clk_sys);
      if (convTick === 1'b1) return;
    end
    bad_count++;
    finish_test;
  endtask
  function automatic logic sca(input logic [31:0] m, input logic [31:0] c);
    return m[11] && !c[4] && !c[2] && (!c[3] || c[0]);
  endfunction
  task automatic cfg(input logic [31:0] m, input logic [31:0] c);
    logic [31:0] d;
    logic [1:0] r;
    logic [2:0] o;
    wr(ModeRegOffset, m, r);
    wr(CtrlRegOffset, c, r);
    rd(ModeRegOffset, d, r);
    chk("mode", m, d & 32'h9fff);
    o = m[15] ? OrderThree : OrderFour;
    rd(StatRegOffset, d, r);
    chk("status", {25'h0, o, 1'b0, m[10], sca(m, c), 1'b0}, d & 32'h76);
    chk("single", 32'(sca(m, c)), 32'(singleCycleActive));
    chk("notch", 32'(m[10]), 32'(dualNotchActive));
    chk("order", 32'(o), 32'(sincOrder));
  endtask
  ////////////////////
  initial begin
    logic [31:0] d, m, c;
    logic [1:0] r;
    int k, i, s, o, p, cyc;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(CtrlRegOffset, d, r);
    chk("ctrl reset", CtrlRegReset, d);
    rd(ModeRegOffset, d, r);
    chk("mode reset", ModeRegReset, d);
    cfg(ModeRegReset, CtrlRegReset);
    rd(8'h10, d, r);
    chk("bad rresp", 32'(RespSlvErr), 32'(r));
    chk("bad rdata", 32'h0, d);
    wr(8'h10, 32'h1, r);
    chk("bad bresp", 32'(RespSlvErr), 32'(r));
    $display("test reset done");
    for (k = 0; k < 12; k++) begin
      m = ($random(seed) & 32'h9fff) | 32'h1;
      c = $random(seed) & 32'h1f;
      cfg(m, c);
    end
    $display("test config done");
    for (k = 0; k < 5; k++) begin
      cfg(tm[k], tc[k]);
      o = tm[k][15] ? 3 : 4;
      p = 1024 * int'(tm[k][9:0]) * (tc[k][0] ? o : 1) * (tm[k][12] ? 2 : 1);
      s = sca(tm[k], tc[k]) ? 1 : o;
      for (i = 1; i <= s; i++) begin
        waitTick(cyc);
        chk("settled", 32'(i == s), 32'(settledResult));
      end
      waitTick(cyc);
      chk("period", p, cyc);
      rd(StatRegOffset, d, r);
      chk("status settled", 32'h1, d & 32'h1);
      $display("test timing %0d done", k);
    end
    finish_test;
  end
endmodule

/* tb/filter_rate_properties.sv */
// Port assertions for the filter rate block.
// Assumes binding to every filter_rate_config instance.
module filter_rate_properties
  import filter_rate_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic bvalid,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [7:0] awaddr,
  input wire logic rvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic [31:0] rdata,
  input wire logic convTick,
  input wire logic settledResult,
  input wire logic singleCycleActive,
  input wire logic dualNotchActive,
  input wire logic [2:0] sincOrder
);
  logic [15:0] gap_q;
  logic [2:0] tick_q;
  logic [7:0] wrAddr_q;
  // Only mode or control writes restart the timing
  wire logic cfgWr = bvalid && wrAddr_q[7:3] == 5'h00;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= '0;
      tick_q <= '0;
      wrAddr_q <= 8'h00;
    end else begin
      gap_q <= (convTick || cfgWr) ? 16'h0 : gap_q + 16'(gap_q != 16'hffff);
      tick_q <= cfgWr ? 3'h0 : tick_q + 3'(convTick && tick_q != 3'h7);
      if (awvalid && awready) begin
        wrAddr_q <= awaddr;
      end
    end
  end
  ////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  tick_pulse_a: assert property (convTick |=> !convTick)
    else $error("tick wider than one cycle");
  settled_tick_a: assert property (settledResult |-> convTick)
    else $error("settled pulse without tick");
  single_settle_a: assert property (convTick && singleCycleActive |-> settledResult)
    else $error("single cycle tick not settled");
  order_range_a: assert property (sincOrder == OrderFour || sincOrder == OrderThree)
    else $error("bad filter order");
  tick_gap_a: assert property (convTick |-> gap_q >= 16'h03e8)
    else $error("ticks too close");
  settle_count_a: assert property (settledResult && !singleCycleActive
    |-> tick_q >= sincOrder - 3'h1)
    else $error("settled too early");
  status_mirror_a: assert property (arvalid && arready && araddr == StatRegOffset
    |=> rdata[2] == dualNotchActive && rdata[6:4] == sincOrder)
    else $error("status differs from ports");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
endmodule

bind filter_rate_config filter_rate_properties filter_rate_properties_inst (
  .clk_sys, .rst_n, .bvalid, .awvalid, .awready, .awaddr, .rvalid, .arvalid, .arready, .araddr,
  .rdata,
  .convTick, .settledResult, .singleCycleActive, .dualNotchActive, .sincOrder);
